// >>> design/lamp_cfg_pkg.sv
// Constants for the status-lamp source and receive termination block.
package lamp_cfg_pkg;

    // Register indices; the byte address is four times the index.
    localparam logic [13:0] LAMP_CFG_IDX = 14'h0460;
    localparam logic [13:0] TERM_CFG_IDX = 14'h0461;

    // Register reset values.
    localparam logic [15:0] LAMP_CFG_RST = 16'h2610;
    localparam logic [15:0] TERM_CFG_RST = 16'h0410;

    // Field positions in lamp_source_config.
    localparam int BLINK_LSB = 12;
    localparam int LAMP_TWO_LSB = 8;
    localparam int LAMP_ONE_LSB = 4;
    localparam int LAMP_ZERO_LSB = 0;

    // Field position in rx_output_termination_config.
    localparam int TERM_LSB = 1;

    // Lamp source codes.
    localparam logic [3:0] SRC_LINK = 4'h0;
    localparam logic [3:0] SRC_LINK_ACT = 4'h1;
    localparam logic [3:0] SRC_LINK_TX = 4'h2;
    localparam logic [3:0] SRC_LINK_MASTER = 4'h4;
    localparam logic [3:0] SRC_LINK_SLAVE = 4'h5;
    localparam logic [3:0] SRC_ACT = 4'h6;
    localparam logic [3:0] SRC_LINK_LOST = 4'h9;
    localparam logic [3:0] SRC_PRBS_ERR = 4'hA;

    // Blink period codes.
    localparam logic [1:0] BLINK_50 = 2'h0;
    localparam logic [1:0] BLINK_100 = 2'h1;
    localparam logic [1:0] BLINK_200 = 2'h2;
    localparam logic [1:0] BLINK_500 = 2'h3;

    // Clock rate and blink periods in their own units.
    localparam int CLK_HZ = 50_000_000;
    localparam int BLINK_50_MS = 50;
    localparam int BLINK_100_MS = 100;
    localparam int BLINK_200_MS = 200;
    localparam int BLINK_500_MS = 500;

    // Blink periods in clock cycles.
    localparam int BLINK_50_CYC = CLK_HZ / 1000 * BLINK_50_MS;
    localparam int BLINK_100_CYC = CLK_HZ / 1000 * BLINK_100_MS;
    localparam int BLINK_200_CYC = CLK_HZ / 1000 * BLINK_200_MS;
    localparam int BLINK_500_CYC = CLK_HZ / 1000 * BLINK_500_MS;

    // Width of the blink counter, enough for the longest period.
    localparam int BLINK_CNT_W = 25;

endpackage : lamp_cfg_pkg

// >>> design/status_lamp_source_control.sv
// Status-lamp source selection, blink timing and termination register.
//
// Summary of operation
// - Blink field bits 13:12 picks 50, 100, 200 or 500 ms, reset 200 ms.
// - Lamp zero code 0000 is link, 0001 link plus activity, 0110 activity.
// - Code 0010 is link plus transmit, 0100 link as master, 0101 as slave.
// - Code 1001 lights on link loss until the status register 0x1 is read.
// - Code 1010 lights on one checker error until its counter is cleared.
// - Lamp two source is bits 11:8 with the same codes and resets to 0110.
// - Lamp one source is bits 7:4 with the same codes and resets to 0001.
// - Bits 4:1 of the impedance register drive the termination, reset 1000.
// - One code serves receive data, clock, error and valid; no per-pin code.
//
// Local design decision: the APB slave port.
module status_lamp_source_control
    import lamp_cfg_pkg::*;
#(
    parameter int BLINK_50_CYCLES  = BLINK_50_CYC,
    parameter int BLINK_100_CYCLES = BLINK_100_CYC,
    parameter int BLINK_200_CYCLES = BLINK_200_CYC,
    parameter int BLINK_500_CYCLES = BLINK_500_CYC
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [15:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        link_good,
    input  wire logic        rx_activity,
    input  wire logic        tx_activity,
    input  wire logic        master_role,
    input  wire logic        status_read,
    input  wire logic        prbs_error,
    input  wire logic        prbs_count_clear,
    output logic             status_lamp_zero,
    output logic             status_lamp_one,
    output logic             status_lamp_two,
    output logic      [3:0]  rx_termination_code
);

    typedef struct packed {
        logic [15:0]            cfg;
        logic [15:0]            imp;
        logic                   ready;
        logic                   slverr;
        logic [31:0]            rdata;
        logic [BLINK_CNT_W-1:0] cnt;
        logic                   blink;
        logic                   link_q;
        logic                   lost;
        logic                   prbs;
        logic                   any_seen;
        logic                   tx_seen;
        logic                   any_hold;
        logic                   tx_hold;
        logic [2:0]             lamp;
        logic [3:0]             term;
    } state_s;

    localparam state_s RESET_ST = '{
        cfg:      LAMP_CFG_RST,
        imp:      TERM_CFG_RST,
        ready:    1'b0,
        slverr:   1'b0,
        rdata:    32'h0000_0000,
        cnt:      '0,
        blink:    1'b0,
        link_q:   1'b0,
        lost:     1'b0,
        prbs:     1'b0,
        any_seen: 1'b0,
        tx_seen:  1'b0,
        any_hold: 1'b0,
        tx_hold:  1'b0,
        lamp:     3'h0,
        term:     TERM_CFG_RST[TERM_LSB +: 4]
    };

    state_s st;
    state_s next_st;

    logic                   access_done;
    logic                   hit_cfg;
    logic                   hit_imp;
    logic                   wrap;
    logic [BLINK_CNT_W-1:0] last_count;

    // Last count of the blink counter for the selected period.
    function automatic logic [BLINK_CNT_W-1:0] period_last(
        input logic [1:0] sel
    );
        logic [BLINK_CNT_W-1:0] value;
        case (sel)
            BLINK_50:  value = BLINK_CNT_W'(BLINK_50_CYCLES - 1);
            BLINK_100: value = BLINK_CNT_W'(BLINK_100_CYCLES - 1);
            BLINK_200: value = BLINK_CNT_W'(BLINK_200_CYCLES - 1);
            BLINK_500: value = BLINK_CNT_W'(BLINK_500_CYCLES - 1);
            default:   value = BLINK_CNT_W'(BLINK_200_CYCLES - 1);
        endcase
        return value;
    endfunction

    // Lamp level for one source code; shared by all three lamps.
    function automatic logic lamp_level(
        input logic [3:0] code,
        input state_s     s,
        input logic       link,
        input logic       master
    );
        logic level;
        case (code)
            SRC_LINK:        level = link;
            SRC_LINK_ACT:    level = link && !(s.any_hold && s.blink);
            SRC_LINK_TX:     level = link && !(s.tx_hold && s.blink);
            SRC_LINK_MASTER: level = link && master;
            SRC_LINK_SLAVE:  level = link && !master;
            SRC_ACT:         level = s.any_hold && s.blink;
            SRC_LINK_LOST:   level = s.lost;
            SRC_PRBS_ERR:    level = s.prbs;
            default:         level = 1'b0;
        endcase
        return level;
    endfunction

    // The slave answers on the second access cycle, so pready is a flop.
    assign access_done = psel && penable && st.ready;
    assign hit_cfg = paddr[15:2] == LAMP_CFG_IDX;
    assign hit_imp = paddr[15:2] == TERM_CFG_IDX;
    assign last_count = period_last(st.cfg[BLINK_LSB +: 2]);
    // A shortened period written while the counter is past it still wraps.
    assign wrap = st.cnt >= last_count;

    always_comb begin
        next_st = st;

        // Bus answer: one wait state, then data and status stand together.
        next_st.ready = psel && penable && !st.ready;
        if (psel && penable && !st.ready) begin
            next_st.slverr = !(hit_cfg || hit_imp);
            if (hit_cfg) begin
                next_st.rdata = {16'h0000, st.cfg};
            end else if (hit_imp) begin
                next_st.rdata = {16'h0000, st.imp};
            end else begin
                next_st.rdata = 32'h0000_0000;
            end
        end else if (!psel) begin
            next_st.slverr = 1'b0;
        end

        if (access_done && pwrite && hit_cfg) begin
            next_st.cfg = pwdata[15:0];
        end
        if (access_done && pwrite && hit_imp) begin
            next_st.imp = pwdata[15:0];
        end

        if (wrap) begin
            next_st.cnt = '0;
            next_st.blink = !st.blink;
        end else begin
            next_st.cnt = st.cnt + BLINK_CNT_W'(1);
        end

        // Activity seen in one period blinks the lamp in the next.
        if (wrap) begin
            next_st.any_hold = st.any_seen || rx_activity || tx_activity;
            next_st.tx_hold = st.tx_seen || tx_activity;
            next_st.any_seen = 1'b0;
            next_st.tx_seen = 1'b0;
        end else begin
            next_st.any_seen = st.any_seen || rx_activity || tx_activity;
            next_st.tx_seen = st.tx_seen || tx_activity;
        end

        // Sticky link loss; a loss in the read cycle is kept.
        next_st.link_q = link_good;
        if (st.link_q && !link_good) begin
            next_st.lost = 1'b1;
        end else if (status_read) begin
            next_st.lost = 1'b0;
        end

        // Sticky checker error; a new error beats the clear.
        if (prbs_error) begin
            next_st.prbs = 1'b1;
        end else if (prbs_count_clear) begin
            next_st.prbs = 1'b0;
        end

        next_st.lamp[0] = lamp_level(st.cfg[LAMP_ZERO_LSB +: 4], st,
                                     link_good, master_role);
        next_st.lamp[1] = lamp_level(st.cfg[LAMP_ONE_LSB +: 4], st,
                                     link_good, master_role);
        next_st.lamp[2] = lamp_level(st.cfg[LAMP_TWO_LSB +: 4], st,
                                     link_good, master_role);

        // One code for the whole receive output group.
        next_st.term = st.imp[TERM_LSB +: 4];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= RESET_ST;
        end else begin
            st <= next_st;
        end
    end

    assign prdata = st.rdata;
    assign pready = st.ready;
    assign pslverr = st.slverr;
    assign status_lamp_zero = st.lamp[0];
    assign status_lamp_one = st.lamp[1];
    assign status_lamp_two = st.lamp[2];
    assign rx_termination_code = st.term;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Blink toggles only on a period wrap.
    chk_blink_toggle_wrap: assert property (
        $changed(st.blink) |-> $past(st.cnt) >= $past(last_count)
    ) else $error("blink phase toggled before the period ended");

    chk_lamp_zero_link: assert property (
        (st.cfg[3:0] == SRC_LINK) && $stable(st.cfg)
        |=> status_lamp_zero == $past(link_good)
    ) else $error("lamp zero does not follow link good");

    // Master code lights only in master role.
    chk_master_role_lamp: assert property (
        (st.cfg[LAMP_ONE_LSB +: 4] == SRC_LINK_MASTER) && link_good
        && !master_role |=> !status_lamp_one
    ) else $error("master lamp lit in slave role");

    // Link loss is caught and held.
    chk_link_loss_hold: assert property (
        st.link_q && !link_good ##1 !status_read [*3] |=> st.lost
    ) else $error("link loss indication not held");

    // A checker error sets the sticky flag.
    chk_prbs_sticky_set: assert property (
        prbs_error ##1 (!prbs_count_clear) [*2] |=> st.prbs
    ) else $error("checker error not held");

    // Activity-only lamp stays dark without activity.
    chk_lamp_two_idle: assert property (
        (st.cfg[11:8] == SRC_ACT) && !st.any_hold |=> !status_lamp_two
    ) else $error("activity lamp lit without activity");

    // Link-plus-activity lamp is dark without link.
    chk_lamp_one_nolink: assert property (
        (st.cfg[7:4] == SRC_LINK_ACT) && !link_good |=> !status_lamp_one
    ) else $error("lamp one lit without link");

    // A written code reaches the drivers two cycles later.
    chk_term_write_out: assert property (
        access_done && pwrite && hit_imp
        |=> ##1 rx_termination_code == $past(pwdata[4:1], 2)
    ) else $error("termination code not applied after write");

    // Reserved codes keep the lamp dark.
    chk_reserved_dark: assert property (
        (st.cfg[3:0] == 4'h7) || (st.cfg[3:0] == 4'hF)
        |=> !status_lamp_zero
    ) else $error("reserved source lit lamp zero");

    // Activity code lights in the on phase.
    chk_lamp_zero_act: assert property (
        (st.cfg[LAMP_ZERO_LSB +: 4] == SRC_ACT) && st.any_hold && st.blink
        |=> status_lamp_zero
    ) else $error("activity lamp dark in its on phase");

    // Link lamp lit outside the blink phase.
    chk_lamp_one_link: assert property (
        (st.cfg[LAMP_ONE_LSB +: 4] == SRC_LINK_ACT) && link_good
        && !(st.any_hold && st.blink) |=> status_lamp_one
    ) else $error("link lamp dark while link is good");

    // Transmit code lit with link and no transmit.
    chk_lamp_two_tx: assert property (
        (st.cfg[LAMP_TWO_LSB +: 4] == SRC_LINK_TX) && link_good
        && !st.tx_hold |=> status_lamp_two
    ) else $error("transmit lamp dark with link and no traffic");

    // Slave code lights in slave role.
    chk_slave_role_lamp: assert property (
        (st.cfg[LAMP_TWO_LSB +: 4] == SRC_LINK_SLAVE) && link_good
        && !master_role |=> status_lamp_two
    ) else $error("slave lamp dark in slave role");

    // A status read clears the loss flag.
    chk_link_loss_clear: assert property (
        status_read && !(st.link_q && !link_good) |=> !st.lost
    ) else $error("link loss flag not cleared by a status read");

    chk_link_loss_lamp: assert property (
        st.cfg[LAMP_ZERO_LSB +: 4] == SRC_LINK_LOST
        |=> status_lamp_zero == $past(st.lost)
    ) else $error("link lost lamp does not show the flag");

    // A counter clear without an error drops the flag.
    chk_prbs_clear: assert property (
        prbs_count_clear && !prbs_error |=> !st.prbs
    ) else $error("checker error flag not cleared");

    chk_prbs_lamp: assert property (
        st.cfg[LAMP_ZERO_LSB +: 4] == SRC_PRBS_ERR
        |=> status_lamp_zero == $past(st.prbs)
    ) else $error("checker error lamp does not show the flag");

    // A register write lands in the configuration.
    chk_cfg_write: assert property (
        access_done && pwrite && hit_cfg |=> st.cfg == $past(pwdata[15:0])
    ) else $error("configuration write lost");

    // The output group code follows the register.
    chk_term_group: assert property (
        1'b1 |=> rx_termination_code == $past(st.imp[TERM_LSB +: 4])
    ) else $error("termination output differs from its register");

    // Codes 0011 and 1000 keep lamp two dark.
    chk_reserved_two: assert property (
        (st.cfg[LAMP_TWO_LSB +: 4] == 4'h3)
        || (st.cfg[LAMP_TWO_LSB +: 4] == 4'h8) |=> !status_lamp_two
    ) else $error("reserved source lit lamp two");

    // Unmapped addresses answer with an error and zero data.
    chk_apb_unmapped: assert property (
        psel && penable && !st.ready && !(hit_cfg || hit_imp)
        |=> pready && pslverr && (prdata == 32'h0000_0000)
    ) else $error("unmapped access not answered with an error");

    chk_apb_ready_pulse: assert property (
        pready |=> !pready
    ) else $error("pready held for more than one cycle");

endmodule // status_lamp_source_control

// >>> verif/lamp_model.sv
// Lamp watcher: counts lamp changes and the cycles between the last two.
module lamp_model (
    input  wire logic  pclk,
    input  wire logic  lamp,
    output int unsigned changes,
    output int unsigned gap
);
    timeunit 1ns;
    timeprecision 1ps;
    logic        last;
    int unsigned run;
    initial begin
        changes = 0;
        gap = 0;
        run = 0;
        last = 1'b0;
    end
    // A lamp pin has no pull, so any change of level counts as a change.
    always @(posedge pclk) begin
        run <= run + 1;
        if (lamp !== last) begin
            changes <= changes + 1;
            gap <= run + 1;
            run <= 0;
        end
        last <= lamp;
    end
endmodule // lamp_model

// >>> verif/tb.sv
// Self-checking bench for the status-lamp and termination block.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import lamp_cfg_pkg::*;
    localparam logic [15:0] LAMP_A = {LAMP_CFG_IDX, 2'b00};
    localparam logic [15:0] TERM_A = {TERM_CFG_IDX, 2'b00};
    localparam int          P0     = 8;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata;
    logic        link_good, rx_activity, tx_activity, master_role;
    logic        status_read, prbs_error, prbs_count_clear;
    wire  [2:0]  lamp;
    logic [3:0]  rx_termination_code;
    int unsigned ch [3];
    int unsigned gp [3];
    int          errors = 0;
    int          total_checks = 0;

    status_lamp_source_control #(.BLINK_50_CYCLES(P0),
        .BLINK_100_CYCLES(2*P0), .BLINK_200_CYCLES(4*P0),
        .BLINK_500_CYCLES(8*P0)) DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .link_good(link_good),
        .rx_activity(rx_activity), .tx_activity(tx_activity),
        .master_role(master_role), .status_read(status_read),
        .prbs_error(prbs_error), .prbs_count_clear(prbs_count_clear),
        .status_lamp_zero(lamp[0]), .status_lamp_one(lamp[1]),
        .status_lamp_two(lamp[2]),
        .rx_termination_code(rx_termination_code));
    for (genvar i = 0; i < 3; i++) begin : g_lamp
        lamp_model u_lamp (.pclk(pclk), .lamp(lamp[i]), .changes(ch[i]),
            .gap(gp[i]));
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time,
                got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // The slave picks its own answer time; only the watchdog ends a wait.
    task automatic apb(input logic w, input logic [15:0] a,
            input logic [31:0] d, output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, q, e);
    endtask
    task automatic rd_chk(input logic [15:0] a, input logic [31:0] x,
            input logic xe);
        logic [31:0] q;
        logic        e;
        apb(1'b0, a, 32'h0, q, e);
        chk(q, x);
        chk(e, xe);
    endtask
    task automatic wait_ch(input int i, input int unsigned n0);
        for (int k = 0; k < 2000 && ch[i] < n0 + 3; k++) @(posedge pclk);
        chk(ch[i] >= n0 + 3, 1'b1);
    endtask

    task automatic t_reset();
        rd_chk(LAMP_A, 32'h2610, 1'b0);
        rd_chk(TERM_A, 32'h0410, 1'b0);
        chk(rx_termination_code, 4'h8);
        rd_chk(16'h0100, 32'h0, 1'b1);
    endtask
    task automatic t_static();
        link_good <= 1'b1;
        master_role <= 1'b1;
        wr(LAMP_A, 32'h2540);
        cyc(3);
        chk(lamp, 3'b011);
        master_role <= 1'b0;
        cyc(3);
        chk(lamp, 3'b101);
        link_good <= 1'b0;
        cyc(3);
        chk(lamp, 3'b000);
    endtask
    task automatic t_reserved();
        link_good <= 1'b1;
        rx_activity <= 1'b1;
        tx_activity <= 1'b1;
        for (int c = 3; c < 16; c++) begin
            if (c inside {4, 5, 6, 9, 10}) continue;
            wr(LAMP_A, 32'h2000 | (c << 8) | (c << 4) | c);
            cyc(3 * P0);
            chk(lamp, 3'b000);
        end
    endtask
    // Blinking needs activity in only one cycle of the previous period, so it is timed by gaps.
    task automatic t_blink();
        tx_activity <= 1'b0;
        for (int b = 0; b < 4; b++) begin
            wr(LAMP_A, (b << 12) | 32'h0216);
            wait_ch(0, ch[0]);
            wait_ch(1, ch[1]);
            chk(gp[0], P0 << b);
            chk(gp[1], P0 << b);
            chk(lamp[2], 1'b1);
        end
        rx_activity <= 1'b0;
        tx_activity <= 1'b1;
        wait_ch(2, ch[2]);
        chk(gp[2], P0 << 3);
        tx_activity <= 1'b0;
    endtask
    task automatic t_link_lost();
        wr(LAMP_A, 32'h2999);
        status_read <= 1'b1;
        cyc(1);
        status_read <= 1'b0;
        cyc(3);
        chk(lamp, 3'b000);
        link_good <= 1'b0;
        cyc(3);
        chk(lamp, 3'b111);
        link_good <= 1'b1;
        cyc(6);
        chk(lamp, 3'b111);
        status_read <= 1'b1;
        cyc(1);
        status_read <= 1'b0;
        cyc(3);
        chk(lamp, 3'b000);
    endtask
    task automatic t_prbs();
        wr(LAMP_A, 32'h2AAA);
        prbs_count_clear <= 1'b1;
        cyc(1);
        prbs_count_clear <= 1'b0;
        cyc(3);
        chk(lamp, 3'b000);
        prbs_error <= 1'b1;
        cyc(1);
        prbs_error <= 1'b0;
        cyc(12);
        chk(lamp, 3'b111);
        prbs_count_clear <= 1'b1;
        cyc(1);
        prbs_count_clear <= 1'b0;
        cyc(3);
        chk(lamp, 3'b000);
        // An error in the clear cycle must still set the flag.
        prbs_error <= 1'b1;
        prbs_count_clear <= 1'b1;
        cyc(1);
        prbs_error <= 1'b0;
        prbs_count_clear <= 1'b0;
        cyc(3);
        chk(lamp, 3'b111);
    endtask
    task automatic t_term();
        wr(TERM_A, 32'h800A);
        cyc(2);
        chk(rx_termination_code, 4'h5);
        rd_chk(TERM_A, 32'h800A, 1'b0);
    endtask

    task automatic report_and_stop();
        $display("errors=%0d checks=%0d", errors, total_checks);
        if (errors == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    initial begin
        // The tests need under two thousand cycles; this leaves a wide margin.
        repeat (20000) @(posedge pclk);
        errors++;
        report_and_stop();
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {link_good, rx_activity, tx_activity, master_role} = '0;
        {status_read, prbs_error, prbs_count_clear} = '0;
        cyc(3);
        presetn <= 1'b1;
        t_reset();
        t_static();
        t_reserved();
        t_blink();
        t_link_lost();
        t_prbs();
        t_term();
        report_and_stop();
    end
endmodule // tb
